/* include/cpsd_map.vh */
/*
 * Constants of the control panel scan and display block: frame layout,
 * command codes, counts and reset values.
 * Assumes it is included by bare name from the design files under rtl/.
 */
`ifndef CPSD_MAP_VH
`define CPSD_MAP_VH

// ****************************************************************
// Frame header layout, first bit on the wire is the header MSB
// ****************************************************************
`define CPSD_HDR_BITS        4
`define CPSD_HDR_ADDR_HI     3
`define CPSD_HDR_ADDR_LO     2
`define CPSD_HDR_CMD_HI      1
`define CPSD_HDR_CMD_LO      0
`define CPSD_CMD_SCAN        2'h1
`define CPSD_CMD_DISPLAY     2'h2

// ****************************************************************
// Switch and LED counts
// ****************************************************************
`define CPSD_SHREG_BITS      8
`define CPSD_SHREG_COUNT     3
`define CPSD_SWITCHES        22
`define CPSD_LEDS            23
`define CPSD_LEDS_USED       22

// ****************************************************************
// Reset values
// ****************************************************************
`define CPSD_LED_RESET       23'h000000
`define CPSD_ADDR_RESET      2'h0

// ****************************************************************
// Frame state codes
// ****************************************************************
`define CPSD_ST_IDLE         3'h0
`define CPSD_ST_HEADER       3'h1
`define CPSD_ST_SCAN         3'h2
`define CPSD_ST_DISPLAY      3'h3
`define CPSD_ST_IGNORE       3'h4

`endif

/* rtl/cpsd_panel.v */
/*
 * Control panel logic: switch scanner, LED driver, panel address latch and
 * decoder, and the serial link to the master frame controller.
 * Assumes all link and switch pins are asynchronous to ref_clk and that
 * each link clock level lasts at least three ref_clk periods.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpsd_map.vh"

module cpsd_panel
#(
   parameter NUM_SWITCHES = `CPSD_SWITCHES,
   parameter NUM_LEDS     = `CPSD_LEDS
)
(
   // Clock and reset
   input  wire                    ref_clk,
   input  wire                    reset,
   // Serial link from the master
   input  wire                    linkClk,
   input  wire                    linkFrameN,
   input  wire                    linkData,
   // Return line to the master
   output wire                    returnData,
   output wire                    returnOe,
   // Panel pins
   input  wire [NUM_SWITCHES-1:0] scanLineN,
   input  wire [1:0]              panel_number_selector,
   output wire [NUM_LEDS-1:0]     ledOn,
   // Status
   output wire [3:0]              panelAddrDecoded
);

   localparam SCAN_BITS = `CPSD_SHREG_BITS * `CPSD_SHREG_COUNT;
   localparam SYNC_W    = 3 + NUM_SWITCHES + 2;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   wire [SYNC_W-1:0] syncIn;
   wire              linkClkS;
   wire              linkFrameNS;
   wire              linkDataS;
   wire [NUM_SWITCHES-1:0] scanLineNS;
   wire [1:0]        selectorS;

   cpsd_sync
   #(
      .WIDTH       (SYNC_W),
      // Link pins reset to idle (frame off, link clock low) so no false edge follows reset.
      .RESET_VALUE ({{2{1'b0}}, {NUM_SWITCHES{1'b1}}, 3'h4})
   )
   u_sync
   (
      .ref_clk (ref_clk),
      .reset   (reset),
      .asyncIn ({panel_number_selector, scanLineN, linkFrameN, linkClk, linkData}),
      .syncOut (syncIn)
   );

   assign linkDataS   = syncIn[0];
   assign linkClkS    = syncIn[1];
   assign linkFrameNS = syncIn[2];
   assign scanLineNS  = syncIn[3 +: NUM_SWITCHES];
   assign selectorS   = syncIn[SYNC_W-1 -: 2];

   // ****************************************************************
   // Link clock edge detect
   // ****************************************************************
   reg  linkClkPrev_ff;
   wire linkRise = linkClkS & ~linkClkPrev_ff;
   wire frameOn  = ~linkFrameNS;

   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         linkClkPrev_ff <= 1'b0;
      else
         linkClkPrev_ff <= linkClkS;
   end

   // ****************************************************************
   // Switch scanner
   // ****************************************************************
   // three eight-bit registers
   // Inputs beyond the fitted switches read as released, the idle level.
   wire [SCAN_BITS-1:0] scanLevels = {{(SCAN_BITS-NUM_SWITCHES){1'b1}}, scanLineNS};
   // low means pressed
   // Pressed switches are sent as ones so an unplugged line reads as idle.
   wire [SCAN_BITS-1:0] pressedBits = ~scanLevels;

   // ****************************************************************
   // Frame state machine
   // ****************************************************************
   reg [2:0]               state_ff;
   reg [2:0]               nxt_state;
   reg [4:0]               bitCnt_ff;
   reg [4:0]               nxt_bitCnt;
   reg [`CPSD_HDR_BITS-1:0] header_ff;
   reg [`CPSD_HDR_BITS-1:0] nxt_header;
   reg [SCAN_BITS-1:0]     txShift_ff;
   reg [SCAN_BITS-1:0]     nxt_txShift;
   reg [NUM_LEDS-1:0]      rxShift_ff;
   reg [NUM_LEDS-1:0]      nxt_rxShift;
   reg [NUM_LEDS-1:0]      led_ff;
   reg [NUM_LEDS-1:0]      nxt_led;
   reg [1:0]               addr_ff;
   reg [1:0]               nxt_addr;
   reg                     retData_ff;
   reg                     nxt_retData;
   reg                     retOe_ff;
   reg                     nxt_retOe;

   wire [`CPSD_HDR_BITS-1:0] hdrFull = {header_ff[`CPSD_HDR_BITS-2:0], linkDataS};
   wire [1:0] hdrAddr = hdrFull[`CPSD_HDR_ADDR_HI:`CPSD_HDR_ADDR_LO];
   wire [1:0] hdrCmd  = hdrFull[`CPSD_HDR_CMD_HI:`CPSD_HDR_CMD_LO];
   wire [3:0] addrOneHot = 4'h1 << addr_ff;
   wire [3:0] hdrOneHot  = 4'h1 << hdrAddr;
   wire [3:0] selOneHot  = 4'h1 << selectorS;
   wire       hdrMatch   = |(hdrOneHot & selOneHot);

   always @*
   begin
      nxt_state   = state_ff;
      nxt_bitCnt  = bitCnt_ff;
      nxt_header  = header_ff;
      nxt_txShift = txShift_ff;
      nxt_rxShift = rxShift_ff;
      nxt_led     = led_ff;
      nxt_addr    = addr_ff;
      nxt_retData = retData_ff;
      nxt_retOe   = retOe_ff;
      if (!frameOn)
      begin
         // A frame cut short leaves the LEDs as they were.
         nxt_state   = `CPSD_ST_IDLE;
         nxt_retOe   = 1'b0;
         nxt_retData = 1'b0;
      end
      else
      begin
         case (state_ff)
            `CPSD_ST_IDLE:
            begin
               nxt_state  = `CPSD_ST_HEADER;
               nxt_bitCnt = 5'h00;
            end
            `CPSD_ST_HEADER:
            begin
               if (linkRise)
               begin
                  nxt_header = hdrFull;
                  nxt_bitCnt = bitCnt_ff + 5'h01;
                  if ({27'h0000000, bitCnt_ff} == `CPSD_HDR_BITS - 1)
                  begin
                     nxt_bitCnt = 5'h00;
                     nxt_addr   = hdrAddr;
                     if (hdrMatch && hdrCmd == `CPSD_CMD_SCAN)
                     begin
                        nxt_state   = `CPSD_ST_SCAN;
                        nxt_txShift = {pressedBits[SCAN_BITS-2:0], 1'b0};
                        nxt_retData = pressedBits[SCAN_BITS-1];
                        nxt_retOe   = 1'b1;
                     end
                     else if (hdrMatch && hdrCmd == `CPSD_CMD_DISPLAY)
                        nxt_state = `CPSD_ST_DISPLAY;
                     else
                        nxt_state = `CPSD_ST_IGNORE;
                  end
               end
            end
            `CPSD_ST_SCAN:
            begin
               if (linkRise)
               begin
                  nxt_bitCnt = bitCnt_ff + 5'h01;
                  if ({27'h0000000, bitCnt_ff} == SCAN_BITS - 1)
                  begin
                     nxt_state   = `CPSD_ST_IGNORE;
                     nxt_retOe   = 1'b0;
                     nxt_retData = 1'b0;
                  end
                  else
                  begin
                     nxt_retData = txShift_ff[SCAN_BITS-1];
                     nxt_txShift = {txShift_ff[SCAN_BITS-2:0], 1'b0};
                  end
               end
            end
            `CPSD_ST_DISPLAY:
            begin
               if (linkRise)
               begin
                  nxt_rxShift = {rxShift_ff[NUM_LEDS-2:0], linkDataS};
                  nxt_bitCnt  = bitCnt_ff + 5'h01;
                  if ({27'h0000000, bitCnt_ff} == NUM_LEDS - 1)
                  begin
                     nxt_led   = {rxShift_ff[NUM_LEDS-2:0], linkDataS};
                     nxt_state = `CPSD_ST_IGNORE;
                  end
               end
            end
            `CPSD_ST_IGNORE:
               nxt_state = `CPSD_ST_IGNORE;
            default:
               nxt_state = `CPSD_ST_IGNORE;
         endcase
      end
   end

   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state_ff   <= `CPSD_ST_IDLE;
         bitCnt_ff  <= 5'h00;
         header_ff  <= {`CPSD_HDR_BITS{1'b0}};
         txShift_ff <= {SCAN_BITS{1'b0}};
         rxShift_ff <= {NUM_LEDS{1'b0}};
         led_ff     <= `CPSD_LED_RESET;
         addr_ff    <= `CPSD_ADDR_RESET;
         retData_ff <= 1'b0;
         retOe_ff   <= 1'b0;
      end
      else
      begin
         state_ff   <= nxt_state;
         bitCnt_ff  <= nxt_bitCnt;
         header_ff  <= nxt_header;
         txShift_ff <= nxt_txShift;
         rxShift_ff <= nxt_rxShift;
         led_ff     <= nxt_led;
         addr_ff    <= nxt_addr;
         retData_ff <= nxt_retData;
         retOe_ff   <= nxt_retOe;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign returnData       = retData_ff;
   assign returnOe         = retOe_ff;
   assign ledOn            = led_ff;
   assign panelAddrDecoded = addrOneHot;

endmodule

`default_nettype wire

/* rtl/cpsd_sync.v */
/*
 * Two flip-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/1ps
`default_nettype none

module cpsd_sync
#(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
)
(
   // Clock and reset
   input  wire             ref_clk,
   input  wire             reset,
   // Levels
   input  wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] stable_ff;

   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         meta_ff   <= RESET_VALUE;
         stable_ff <= RESET_VALUE;
      end
      else
      begin
         meta_ff   <= asyncIn;
         stable_ff <= meta_ff;
      end
   end

   assign syncOut = stable_ff;

endmodule

`default_nettype wire

/* verification/control_panel_scan_and_display_test.sv */
/*
 * Self-checking bench for the panel block, driving it through the master model.
 * Assumes the checker is bound to the block and the design defaults are kept.
 */
`timescale 1ns/1ps
`default_nettype none

module control_panel_scan_and_display_test;
   logic        refClk;
   logic        reset;
   logic        linkClk;
   logic        linkFrameN;
   logic        linkData;
   logic        returnData;
   logic        returnOe;
   logic        returnLine;
   logic [21:0] scanLineN;
   logic [1:0]  panelSel;
   logic [22:0] ledOn;
   logic [3:0]  panelAddrDecoded;
   logic [23:0] got;
   logic [22:0] ledExp;
   int          badCount;
   int          testsRun;

   cpsd_panel i_dut
   (
      .ref_clk(refClk),
      .reset(reset),
      .linkClk(linkClk),
      .linkFrameN(linkFrameN),
      .linkData(linkData),
      .returnData(returnData),
      .returnOe(returnOe),
      .scanLineN(scanLineN),
      .panel_number_selector(panelSel),
      .ledOn(ledOn),
      .panelAddrDecoded(panelAddrDecoded)
   );

   // The shared return line idles high through its pull-up when no panel drives it.
   assign returnLine = returnOe ? returnData : 1'b1;

   cpsd_master i_master
   (
      .ref_clk(refClk),
      .linkClk(linkClk),
      .linkFrameN(linkFrameN),
      .linkData(linkData),
      .returnData(returnLine)
   );

   // ****************************************************************
   // Checking and closing
   // ****************************************************************
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         badCount++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stopTest;
      $display("Checks %0d, mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic testScan(input logic [21:0] sw);
      scanLineN = sw;
      repeat (4) @(negedge refClk);
      i_master.xfer(4'h5, 24'h000000, 24, got);
      check(got, {2'b00, ~sw});
      check(panelAddrDecoded, 4'h2);
   endtask

   task automatic testDisplayAll;
      for (int s = 0; s < 4; s++)
      begin
         panelSel = s[1:0];
         ledExp = 23'h5A3C96 ^ {s[1:0], 21'h0};
         repeat (4) @(negedge refClk);
         i_master.xfer({s[1:0], 2'h2}, {1'b0, ledExp}, 23, got);
         check(ledOn, ledExp);
         check(panelAddrDecoded, 4'h1 << s);
      end
   endtask

   // Foreign address, bad commands and a short frame leave the LEDs alone.
   task automatic testIgnored;
      i_master.xfer(4'h2, 24'h7FFFFF, 23, got);
      check(ledOn, ledExp);
      check(panelAddrDecoded, 4'h1);
      i_master.xfer(4'h1, 24'h000000, 24, got);
      check(got, 24'hFFFFFF);
      i_master.xfer(4'hC, 24'h000000, 24, got);
      check(got, 24'hFFFFFF);
      i_master.xfer(4'hF, 24'h7FFFFF, 23, got);
      check(ledOn, ledExp);
      i_master.xfer(4'hE, 24'h3FFFFF, 22, got);
      check(ledOn, ledExp);
      i_master.xfer(4'hE, 24'h412345, 23, got);
      check(ledOn, 23'h412345);
   endtask

   initial
   begin
      refClk = 1'b0;
      forever #25 refClk = ~refClk;
   end

   initial
   begin
      #1ms;
      badCount++;
      stopTest();
   end

   initial
   begin
      badCount = 0;
      testsRun = 0;
      reset = 1'b1;
      scanLineN = 22'h3FFFFF;
      panelSel = 2'h1;
      repeat (5) @(negedge refClk);
      reset = 1'b0;
      repeat (3) @(negedge refClk);
      check(ledOn, 23'h000000);
      check(returnOe, 1'b0);
      check(panelAddrDecoded, 4'h1);
      testScan(22'h2A5C31);
      testScan(22'h000000);
      testScan(22'h3FFFFF);
      testDisplayAll();
      testIgnored();
      stopTest();
   end
endmodule

`default_nettype wire

/* verification/cpsd_master.sv */
/*
 * Model of the master frame controller at the far end of the panel link.
 * Assumes ref_clk runs; every link change is made at its falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module cpsd_master
(
   // Clock
   input  wire logic ref_clk,
   // Link
   output var  logic linkClk,
   output var  logic linkFrameN,
   output var  logic linkData,
   input  wire logic returnData
);
   // Each link clock level lasts five reference cycles, above the minimum of three.
   localparam int HALF = 5;

   initial
   begin
      linkClk = 1'b0;
      linkFrameN = 1'b1;
      linkData = 1'b1;
   end

   // Header then payload MSB first; answer sampled before each payload rise.
   task automatic xfer(input logic [3:0] hdr, input logic [23:0] pay, input int n,
                       output logic [23:0] got);
      got = 24'h000000;
      @(negedge ref_clk);
      linkFrameN = 1'b0;
      repeat (3) @(negedge ref_clk);
      for (int i = 0; i < n + 4; i++)
      begin
         linkData = (i < 4) ? hdr[3 - i] : pay[n + 3 - i];
         repeat (HALF) @(negedge ref_clk);
         if (i >= 4)
            got = {got[22:0], returnData};
         linkClk = 1'b1;
         repeat (HALF) @(negedge ref_clk);
         linkClk = 1'b0;
      end
      repeat (HALF) @(negedge ref_clk);
      linkFrameN = 1'b1;
      // A released data line must not keep showing the last bit.
      linkData = ~linkData;
      repeat (6) @(negedge ref_clk);
   endtask
endmodule

`default_nettype wire

/* verification/cpsd_panel_sva.sv */
/*
 * Port checker for the panel block: return line, LED and address behaviour.
 * Assumes it is bound to cpsd_panel and that the block has one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module cpsd_panel_sva
#(
   parameter NUM_SWITCHES = 22,
   parameter NUM_LEDS     = 23
)
(
   // Clock and reset
   input wire logic                    ref_clk,
   input wire logic                    reset,
   // Link
   input wire logic                    linkClk,
   input wire logic                    linkFrameN,
   input wire logic                    linkData,
   input wire logic                    returnData,
   input wire logic                    returnOe,
   // Panel pins
   input wire logic [NUM_SWITCHES-1:0] scanLineN,
   input wire logic [1:0]              panel_number_selector,
   input wire logic [NUM_LEDS-1:0]     ledOn,
   input wire logic [3:0]              panelAddrDecoded
);
   logic [3:0] selHot;

   assign selHot = 4'h1 << panel_number_selector;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // The gap of six cycles covers the frame synchroniser and the output register.
   a_idle_no_drive: assert property (linkFrameN [*6] |-> !returnOe)
      else $error("return line driven outside a frame");
   a_quiet_when_off: assert property (!returnOe |-> !returnData)
      else $error("return data high while not driving");
   a_scan_top_zero: assert property ($rose(returnOe) |-> !returnData)
      else $error("first scan bit is not the unused zero");
   a_scan_needs_match: assert property ($rose(returnOe) |-> panelAddrDecoded == selHot)
      else $error("scan answered for another panel");
   a_led_needs_match: assert property ($changed(ledOn) |-> panelAddrDecoded == selHot)
      else $error("LEDs changed for another panel");
   a_decode_onehot: assert property ($onehot(panelAddrDecoded))
      else $error("decoded address is not one-hot");
   a_idle_led_hold: assert property (linkFrameN [*6] |-> $stable(ledOn))
      else $error("LEDs changed outside a frame");
   a_idle_addr_hold: assert property (linkFrameN [*6] |-> $stable(panelAddrDecoded))
      else $error("address changed outside a frame");
   a_answer_in_frame: assert property ($rose(returnOe) |-> !$past(linkFrameN, 3))
      else $error("answer started without a frame");

   c_scan: cover property ($rose(returnOe));
   c_scan_end: cover property ($fell(returnOe));
   c_display: cover property ($changed(ledOn));
endmodule

bind cpsd_panel cpsd_panel_sva
#(
   .NUM_SWITCHES(NUM_SWITCHES),
   .NUM_LEDS(NUM_LEDS)
)
i_sva
(
   .ref_clk(ref_clk),
   .reset(reset),
   .linkClk(linkClk),
   .linkFrameN(linkFrameN),
   .linkData(linkData),
   .returnData(returnData),
   .returnOe(returnOe),
   .scanLineN(scanLineN),
   .panel_number_selector(panel_number_selector),
   .ledOn(ledOn),
   .panelAddrDecoded(panelAddrDecoded)
);

`default_nettype wire
